// File: core/spiatn_slave.sv
`timescale 1ns/100ps
`default_nettype none
module spiatn_slave
  import spiatn_pkg::*;
#(
  parameter int BW = SPIATN_BYTE_BITS
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  spiatn_if.slave link,
  input wire logic [BW-1:0] i_tx_data,  // outbound byte
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic [BW-1:0] o_rx_data,      // inbound byte
  output logic o_rx_valid,
  input wire logic i_rx_ready
);
  // ==========================================================
  // operation notes
  // ==========================================================
  // the master owns both the serial clock and the select; this end
  // only watches them, so a byte moves only when the master runs it
  //
  // transmit path:
  //   user bytes enter a two-slot buffer, so the producer can queue
  //   the next byte while the current one is on the wire
  //   while deselected the shift register keeps reloading from the
  //   head of the buffer, or from the idle byte when it is empty
  //   a flag records whether the shift register holds a real byte;
  //   only such a byte leaves the buffer at the end of its frame
  //   a byte pushed after select fell therefore waits for the next
  //   frame instead of being popped unsent
  //
  // receive path:
  //   every eighth sampled rise completes one inbound byte, which
  //   stays valid until the user accepts it; a newer byte overwrites
  //   an unread one, so a slow user loses data, not framing
  //
  // attention:
  //   low as long as the buffer or the shift register holds a real
  //   byte; it returns high on the rise that takes the last bit, so
  //   the master never fetches a byte that is not there
  //
  // line release:
  //   the data out enable follows select one core cycle late; the
  //   master samples its first bit half a serial period after select
  //   falls, which leaves ample margin for that lag
  //
  // cut frames:
  //   a deselect in mid-byte clears the bit count and reloads the
  //   head byte, so the cut byte is sent again in the next frame
  //
  // limitation: pins are taken as synchronous to the core clock, so
  // a master running from another clock needs its own synchroniser
  // ==========================================================
  // pin sampling
  // ==========================================================
  // link pins are taken as synchronous; one stage gives edge history
  logic sclk_q;
  wire logic rise = link.sclk & ~sclk_q & ~link.sel_n;
  wire logic fall = ~link.sclk & sclk_q & ~link.sel_n;
  // edges come only from the master's clock; nothing here toggles it
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sclk_q <= 1'b0;
    end
    else
    begin
      sclk_q <= link.sclk;
    end
  end
  // ==========================================================
  // two-entry transmit buffer
  // ==========================================================
  // two slots so the producer keeps flowing during a byte shift
  logic [BW-1:0] tbuf [2];
  logic [1:0] tcnt;      // entries held
  logic twp;             // write slot
  logic trp;             // read slot
  logic [BW-1:0] shreg;  // shift register
  logic [2:0] bitc;      // bits shifted this byte
  logic loaded;          // shift register holds a real byte
  logic [BW-1:0] rx_q;
  logic rx_v;
  wire logic t_push = i_tx_valid & o_tx_ready;
  wire logic byte_end = rise & (bitc == SPIATN_LAST_BIT);
  // only a byte that was really on the wire leaves the buffer
  wire logic t_pop = byte_end & loaded;
  wire logic [BW-1:0] next_byte = (tcnt != 2'h0) ? tbuf[trp] : SPIATN_IDLE_BYTE;
  wire logic [1:0] next_tcnt = tcnt + {1'b0, t_push} - {1'b0, t_pop};
  // buffer bookkeeping
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      tcnt <= 2'h0;
      twp <= 1'b0;
      trp <= 1'b0;
      o_tx_ready <= 1'b1;
    end
    else
    begin
      tcnt <= next_tcnt;
      twp <= twp ^ t_push;
      trp <= trp ^ t_pop;
      o_tx_ready <= (next_tcnt != 2'h2);
    end
  end
  // slot storage needs no reset
  always_ff @(posedge i_core_clk)
  begin
    if (t_push)
      tbuf[twp] <= i_tx_data;
  end
  // ==========================================================
  // shifter
  // ==========================================================
  // mode 0: sample on rise, next bit shown after that same rise
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      shreg <= SPIATN_IDLE_BYTE;
      bitc <= SPIATN_FIRST_BIT;
      loaded <= 1'b0;
    end
    else if (link.sel_n)
    begin
      // deselect aborts the byte; a partly sent byte is resent
      bitc <= SPIATN_FIRST_BIT;
      shreg <= next_byte;
      loaded <= (tcnt != 2'h0);
    end
    else if (rise)
    begin
      bitc <= bitc + 3'h1;
      shreg <= {shreg[BW-2:0], link.mosi};
      if (byte_end)
        loaded <= 1'b0;
    end
    else if (fall && bitc == SPIATN_FIRST_BIT && !loaded)
    begin
      // new byte loaded at the boundary, msb onto the line
      shreg <= next_byte;
      loaded <= (tcnt != 2'h0);
    end
  end
  // receive side, one byte per eight rising edges
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rx_q <= '0;
      rx_v <= 1'b0;
    end
    else if (byte_end)
    begin
      // bytes pass through unchanged; packet framing is the user's job
      rx_q <= {shreg[BW-2:0], link.mosi};
      rx_v <= 1'b1; // a new byte wins over an accept
    end
    else if (i_rx_ready)
      rx_v <= 1'b0;
  end
  assign o_rx_data = rx_q;
  assign o_rx_valid = rx_v;
  // ==========================================================
  // pin drivers
  // ==========================================================
  logic miso_r;
  logic oe_n_r;
  logic attn_r;
  // attention stays low until buffer and shifter both drain
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      miso_r <= 1'b1;
      oe_n_r <= 1'b1;
      attn_r <= 1'b1;
    end
    else
    begin
      miso_r <= shreg[BW-1];
      oe_n_r <= link.sel_n;
      attn_r <= ~((next_tcnt != 2'h0) | (loaded & ~byte_end));
    end
  end
  assign link.miso_o = miso_r;
  assign link.miso_oe_n = oe_n_r;
  assign link.host_attention_n = attn_r;
endmodule : spiatn_slave
`default_nettype wire

// File: core/spiatn_pkg.sv
package spiatn_pkg;
  // ==========================================================
  // link timing
  // ==========================================================
  // highest serial clock rate, in kb/s
  localparam int SPIATN_MAX_RATE_KBPS = 3500;
  // core clock rate, in kHz
  localparam int SPIATN_CORE_KHZ = 100000;
  // core cycles per half serial clock period, least time rounds up
  localparam int SPIATN_HALF_CYCLES =
    (SPIATN_CORE_KHZ + 2 * SPIATN_MAX_RATE_KBPS - 1) / (2 * SPIATN_MAX_RATE_KBPS);
  // ==========================================================
  // byte framing
  // ==========================================================
  localparam int SPIATN_BYTE_BITS = 8;
  localparam logic [2:0] SPIATN_LAST_BIT = 3'h7;
  localparam logic [2:0] SPIATN_FIRST_BIT = 3'h0;
  localparam logic [7:0] SPIATN_IDLE_BYTE = 8'hff;
  // packet start marker; the link carries it like any other byte
  localparam logic [7:0] SPIATN_FRAME_START = 8'h7e;
endpackage : spiatn_pkg

// File: core/spiatn_if.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// four-wire serial link plus attention line
// ============================================================
interface spiatn_if;
  logic sclk;        // serial clock, master driven
  logic sel_n;       // slave select, active low
  logic mosi;        // master out, slave in
  logic miso_o;      // slave data out value
  logic miso_oe_n;   // slave data enable, low while driving
  logic host_attention_n; // attention, always driven by slave
  wire miso;         // resolved shared line
  assign miso = miso_oe_n ? 1'b1 : miso_o; // pull-up when released
  modport slave (input sclk, sel_n, mosi, output miso_o, miso_oe_n, host_attention_n);
  modport master (output sclk, sel_n, mosi, input miso, host_attention_n);
endinterface : spiatn_if
`default_nettype wire

// File: core/spiatn_master.sv
`timescale 1ns/100ps
`default_nettype none
module spiatn_master
  import spiatn_pkg::*;
#(
  parameter int BW = SPIATN_BYTE_BITS,
  parameter int HALF = SPIATN_HALF_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  spiatn_if.master link,
  input wire logic [BW-1:0] i_tx_data,  // byte to send
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic [BW-1:0] o_rx_data,      // byte received
  output logic o_rx_valid
);
  // ==========================================================
  // clock divider and byte engine
  // ==========================================================
  typedef enum logic [1:0] {M_IDLE, M_LOW, M_HIGH} spiatn_mst_t;
  spiatn_mst_t st;
  logic [7:0] div;
  logic [2:0] bitc;
  logic [BW-1:0] sh;
  logic sclk_r, sel_r, mosi_r;
  // start when user has a byte or slave raises attention
  wire logic go = i_tx_valid | ~link.host_attention_n;
  wire logic tick = (div == 8'(HALF - 1));
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st <= M_IDLE;
      div <= 8'h0;
      bitc <= SPIATN_FIRST_BIT;
      sh <= '0;
      sclk_r <= 1'b0;
      sel_r <= 1'b1;
      mosi_r <= 1'b1;
      o_tx_ready <= 1'b0;
      o_rx_data <= '0;
      o_rx_valid <= 1'b0;
    end
    else
    begin
      o_tx_ready <= 1'b0;
      o_rx_valid <= 1'b0;
      div <= (st == M_IDLE || tick) ? 8'h0 : div + 8'h1;
      unique case (st)
        M_IDLE:
        begin
          sclk_r <= 1'b0;
          if (go)
          begin
            sel_r <= 1'b0;
            sh <= i_tx_valid ? i_tx_data : SPIATN_IDLE_BYTE;
            mosi_r <= i_tx_valid ? i_tx_data[BW-1] : 1'b1;
            o_tx_ready <= i_tx_valid;
            bitc <= SPIATN_FIRST_BIT;
            st <= M_LOW;
          end
          else
            sel_r <= 1'b1;
        end
        M_LOW:
          if (tick)
          begin
            sclk_r <= 1'b1;
            sh <= {sh[BW-2:0], link.miso};
            st <= M_HIGH;
          end
        M_HIGH:
          if (tick)
          begin
            sclk_r <= 1'b0;
            bitc <= bitc + 3'h1;
            mosi_r <= sh[BW-1];
            st <= M_LOW;
            if (bitc == SPIATN_LAST_BIT)
            begin
              o_rx_data <= sh;
              o_rx_valid <= 1'b1;
              sel_r <= 1'b1; // one idle cycle deselected between bytes
              st <= M_IDLE;
            end
          end
        default: st <= M_IDLE;
      endcase
    end
  end
  assign link.sclk = sclk_r;
  assign link.sel_n = sel_r;
  assign link.mosi = mosi_r;
endmodule : spiatn_master
`default_nettype wire

// File: bench/spiatn_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// link checker
// ==========
module spiatn_checker (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe_n,
  input wire logic host_attention_n
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  logic [3:0] n_rise; // serial rises in this frame
  // one frame is one byte, so the count clears on deselect
  always_ff @(posedge i_core_clk or negedge i_reset_n)
    if (!i_reset_n) n_rise <= 4'h0;
    else if (sel_n) n_rise <= 4'h0;
    else if ($rose(sclk)) n_rise <= n_rise + 4'h1;
  sequence s_quiet; !sclk [*8]; endsequence
  sequence s_held; $stable(sclk) [*7]; endsequence
  property p_idle_low; sel_n |-> !sclk; endproperty
  property p_released; sel_n && $past(sel_n) |-> miso_oe_n; endproperty
  property p_driving; $fell(sel_n) |=> !miso_oe_n; endproperty
  property p_setup; $fell(sel_n) |-> s_quiet; endproperty
  property p_rate; $changed(sclk) |=> s_held; endproperty
  property p_steady; $rose(sclk) |-> $stable(mosi) && $stable(miso_o); endproperty
  property p_byte; $rose(sel_n) |-> n_rise == 4'h8; endproperty
  // slave lets go only once the last bits are nearly clocked out
  property p_attn_hold; $rose(host_attention_n) |-> !sel_n && n_rise >= 4'h7; endproperty
  a_idle_low: assert property (p_idle_low) else $error("clock not low when idle");
  a_released: assert property (p_released) else $error("data out not released");
  a_driving: assert property (p_driving) else $error("data out not driven");
  a_setup: assert property (p_setup) else $error("clock before setup");
  a_rate: assert property (p_rate) else $error("serial clock too fast");
  a_steady: assert property (p_steady) else $error("data moved at rise");
  a_byte: assert property (p_byte) else $error("frame not eight rises");
  a_attn_hold: assert property (p_attn_hold) else $error("attention left early");
endmodule : spiatn_checker
`default_nettype wire

// File: bench/spi_slave_port_with_attention_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// master and slave joined back to back
// ==========
module spi_slave_port_with_attention_tb;
  import spiatn_pkg::*;
  typedef struct packed {logic [7:0] md; logic [7:0] sd; logic has;} spiatn_row_t;
  logic clk = 1'b0, rst_n = 1'b0, m_tv = 1'b0, s_tv = 1'b0, s_rr = 1'b0;
  logic m_tr, m_rv, s_tr, s_rv;
  logic [7:0] m_td = 8'h00, s_td = 8'h00, m_rd, s_rd, sh_mosi, sh_miso;
  int n_errors = 0, checks = 0;
  wire [2:0] ev = {m_tr, m_rv, s_rv}; // events a wait blocks on
  // rows: master byte, slave byte, slave has data
  spiatn_row_t rows [4] = '{'{8'h7e, 8'h81, 1'b1}, '{8'h00, 8'hff, 1'b1},
    '{8'ha5, 8'h00, 1'b0}, '{8'hff, 8'h3c, 1'b1}};
  always #5 clk = ~clk; // 100 MHz
  spiatn_if lk();
  spiatn_master spiatn_master_i (.i_core_clk(clk), .i_reset_n(rst_n), .link(lk.master),
    .i_tx_data(m_td), .i_tx_valid(m_tv), .o_tx_ready(m_tr), .o_rx_data(m_rd), .o_rx_valid(m_rv));
  spiatn_slave spiatn_slave_i (.i_core_clk(clk), .i_reset_n(rst_n), .link(lk.slave),
    .i_tx_data(s_td), .i_tx_valid(s_tv), .o_tx_ready(s_tr), .o_rx_data(s_rd),
    .o_rx_valid(s_rv), .i_rx_ready(s_rr));
  spiatn_checker spiatn_checker_i (.i_core_clk(clk), .i_reset_n(rst_n), .sclk(lk.sclk),
    .sel_n(lk.sel_n), .mosi(lk.mosi), .miso_o(lk.miso_o), .miso_oe_n(lk.miso_oe_n),
    .host_attention_n(lk.host_attention_n));
  // wire-level view: collect bits in order of the rises
  always @(posedge lk.sclk) sh_mosi <= {sh_mosi[6:0], lk.mosi};
  always @(posedge lk.sclk) sh_miso <= {sh_miso[6:0], lk.miso};
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // bounded wait; a byte takes some 240 cycles, so the bound is generous
  task automatic wait_ev(input int k);
    int i;
    for (i = 0; i < 5000 && ev[k] !== 1'b1; i++) @(negedge clk);
    if (i == 5000)
    begin
      n_errors++;
      tally_and_finish;
    end
  endtask : wait_ev
  // caller sees slave ready high before this
  task automatic push(input logic [7:0] d);
    s_td = d;
    s_tv = 1'b1;
    @(negedge clk);
    s_tv = 1'b0;
  endtask : push
  task automatic rx_end(input logic [7:0] md, input logic [7:0] exp_m, input logic exp_attn);
    wait_ev(1);
    chk(m_rd, exp_m, "master rx");
    chk(sh_miso, exp_m, "miso wire");
    chk(sh_mosi, md, "mosi wire");
    wait_ev(0);
    chk(s_rd, md, "slave rx");
    s_rr = 1'b1;
    @(negedge clk);
    s_rr = 1'b0;
    repeat (20) @(negedge clk);
    chk({7'h00, lk.host_attention_n}, {7'h00, exp_attn}, "attention");
  endtask : rx_end
  // host byte offered at once, so it wins over a fetch on attention
  task automatic xfer(input logic [7:0] md, input logic [7:0] exp_m, input logic exp_attn);
    m_td = md;
    m_tv = 1'b1;
    wait_ev(2);
    m_tv = 1'b0;
    @(negedge clk);
    rx_end(md, exp_m, exp_attn);
  endtask : xfer
  // attention high and driven, line released, clock low, select high
  task automatic rst_chk;
    chk({4'h0, lk.host_attention_n, lk.miso, lk.sel_n, lk.sclk}, 8'h0e, "reset lines");
  endtask : rst_chk
  initial
  begin
    repeat (6) @(negedge clk);
    rst_chk;
    rst_n = 1'b1;
    @(negedge clk);
    foreach (rows[r])
    begin
      if (rows[r].has)
        push(rows[r].sd);
      chk({7'h00, lk.host_attention_n}, {7'h00, !rows[r].has}, "attention");
      xfer(rows[r].md, rows[r].has ? rows[r].sd : SPIATN_IDLE_BYTE, 1'b1);
    end
    // two queued bytes fill the buffer; attention must hold across both
    s_td = 8'h11;
    s_tv = 1'b1;
    @(negedge clk);
    s_td = 8'h22;
    m_td = 8'h5a;
    m_tv = 1'b1;
    @(negedge clk);
    s_tv = 1'b0;
    chk({7'h00, s_tr}, 8'h00, "tx full");
    wait_ev(2);
    m_tv = 1'b0;
    @(negedge clk);
    rx_end(8'h5a, 8'h11, 1'b0);
    // attention still low, so the master fetches the second byte unasked
    rx_end(SPIATN_IDLE_BYTE, 8'h22, 1'b1);
    // reset cut into a running byte
    m_td = 8'h99;
    m_tv = 1'b1;
    wait_ev(2);
    m_tv = 1'b0;
    repeat (50) @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    rst_chk;
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    tally_and_finish;
  end
endmodule : spi_slave_port_with_attention_tb
`default_nettype wire
